// File: rtl/duhp_host_port.sv
/*
 * duhp_host_port: host bus and pin logic of a two-channel serial device.
 * Bus pins are synchronous to i_mclk; the strap is static after reset.
 */
// Function
// - three address bits pick one of eight registers; 8-bit two-way data bus
// - strobe mode: read strobe fall starts read, device drives byte until rise
// - strobe mode: write strobe fall starts write, data loaded at rising edge
// - R/W mode: write strobe pin is direction, high reads, low writes
// - strobe mode: two active-low chip selects, one per channel
// - R/W mode: first select is chip select, second is channel address bit
// - strobe mode: modem control bit 3 drives irq and pulls out2 low
// - reset clears bit 3: irq three-stated except channel a in R/W mode, out2 high
// - active-low transmit ready per channel from transmit FIFO status
// - active-low receive ready per channel follows the received bit, asserted while it is low
// - bit 6 clear: standard serial, output high in reset and idle
// - bit 6 set: infrared encode/decode, encoder rests low
// - receive idles high; infrared pulses optionally inverted by feature bit 2
// - active-low request-to-send general output from modem control bit 1, no auto flow
// - request-to-send does RS485 direction control per feature and mode bit 3
// - clear-to-send readable; gates transmit when enhanced feature bit 7 set
// - active-low terminal-ready output driven by software
// - set-ready, carrier, ring inputs readable only, no effect on transfer
`timescale 1ns/1ps
module duhp_host_port (
	// clock and reset
	input  wire logic       i_mclk,
	input  wire logic       i_reset,
	// bus style strap, high selects strobe style
	input  wire logic       i_bus_style,
	// host bus
	input  wire logic [2:0] i_addr,
	input  wire logic [7:0] i_data,
	output logic      [7:0] o_data,
	output logic            o_data_oe,
	input  wire logic       i_read_strobe_n,
	input  wire logic       i_write_strobe_n,
	input  wire logic       i_chan_a_select_n,
	input  wire logic       i_chan_b_select_n,
	// interrupts and general outputs
	input  wire logic [1:0] i_irq_pending,
	output logic            o_chan_a_irq,
	output logic            o_chan_a_irq_oe,
	output logic            o_chan_b_irq,
	output logic            o_chan_b_irq_oe,
	output logic            o_chan_a_gp_out2_n,
	output logic            o_chan_b_gp_out2_n,
	// ready outputs
	output logic            o_chan_a_tx_ready_n,
	output logic            o_chan_a_rx_ready_n,
	output logic            o_chan_b_tx_ready_n,
	output logic            o_chan_b_rx_ready_n,
	// serial and modem pins, index 0 is channel a
	output logic [1:0]      o_serial_out,
	input  wire logic [1:0] i_serial_in,
	output logic [1:0]      o_request_send_n,
	input  wire logic [1:0] i_clear_send_n,
	output logic [1:0]      o_terminal_ready_n,
	input  wire logic [1:0] i_set_ready_n,
	input  wire logic [1:0] i_carrier_n,
	input  wire logic [1:0] i_ring_n
);
	typedef enum logic [1:0] {TX_IDLE, TX_SHIFT} duhp_tx_state_type;

	logic       style_ff;
	logic       rd_n_ff;
	logic       wr_n_ff;
	logic [1:0] sel;
	logic       rd_act;
	logic       wr_act;
	logic       rd_start;
	logic       wr_done;
	logic [7:0] rd_data [2];
	logic [7:0] nxt_data;

	// strap captured once at reset release; later pin changes do nothing
	always_ff @(posedge i_mclk)
	begin
		if (i_reset)
			style_ff <= i_bus_style;
	end

	always_ff @(posedge i_mclk)
	begin
		if (i_reset)
		begin
			rd_n_ff <= 1'b1;
			wr_n_ff <= 1'b1;
		end
		else
		begin
			rd_n_ff <= i_read_strobe_n;
			wr_n_ff <= i_write_strobe_n;
		end
	end

	// channel select per bus style
	always_comb
	begin
		if (style_ff)
			sel = {~i_chan_b_select_n, ~i_chan_a_select_n};
		else if (!i_chan_a_select_n)
			sel = i_chan_b_select_n ? 2'b10 : 2'b01;
		else
			sel = 2'b00;
	end

	// R/W style: select low with direction high reads, low writes
	assign rd_act   = style_ff ? !i_read_strobe_n : (i_write_strobe_n && (sel != 2'b00));
	assign rd_start = style_ff && rd_n_ff && !i_read_strobe_n;
	assign wr_done  = style_ff && !wr_n_ff && i_write_strobe_n;
	assign wr_act   = style_ff ? wr_done : (!i_write_strobe_n && (sel != 2'b00));
	assign nxt_data = sel[1] ? rd_data[1] : rd_data[0];

	// data driven while a read is active; strobe style samples at strobe fall, R/W style every cycle
	always_ff @(posedge i_mclk)
	begin
		if (i_reset)
		begin
			o_data    <= 8'h00;
			o_data_oe <= 1'b0;
		end
		else
		begin
			if (rd_start || (!style_ff && rd_act))
				o_data <= nxt_data;
			o_data_oe <= rd_act && (sel != 2'b00);
		end
	end

	logic [1:0] irq_oe;
	logic [1:0] tx_rdy;
	logic [1:0] rx_rdy;

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++)
		begin : g_chan
			logic [7:0] mcr_ff, feature_control_reg_ff, efr_ff, enhanced_mode_select_reg_ff, thr_ff;
			logic       wr_chan;
			logic       tx_in_ready, tx_valid, tx_pop;
			logic [7:0] tx_byte;
			logic [3:0] tx_level;
			duhp_tx_state_type tx_state_ff;
			logic [3:0] bit_ff;
			logic [4:0] tick_ff;
			logic [9:0] shift_ff;
			logic       line_ff;
			logic       rx_bit;
			logic       cts_ok;

			// in R/W style a write lands on the cycle the select is seen low
			assign wr_chan = wr_act && sel[ch];

			always_ff @(posedge i_mclk)
			begin
				if (i_reset)
				begin
					mcr_ff  <= duhp_pkg::MCR_RESET;
					feature_control_reg_ff <= duhp_pkg::CFG_RESET;
					efr_ff  <= duhp_pkg::CFG_RESET;
					enhanced_mode_select_reg_ff <= duhp_pkg::CFG_RESET;
					thr_ff  <= duhp_pkg::THR_RESET;
				end
				else if (wr_chan)
				begin
					if (i_addr == duhp_pkg::REG_MODEM_CTL)
						mcr_ff <= i_data;
					else if (i_addr == duhp_pkg::REG_FEATURE)
						feature_control_reg_ff <= i_data;
					else if (i_addr == duhp_pkg::REG_ENH_FEAT)
						efr_ff <= i_data;
					else if (i_addr == duhp_pkg::REG_ENH_MODE)
						enhanced_mode_select_reg_ff <= i_data;
					else if (i_addr == duhp_pkg::REG_READY_THR)
						thr_ff <= i_data;
				end
			end

			duhp_fifo #(.WIDTH(8), .DEPTH(duhp_pkg::FIFO_DEPTH)) u_tx_fifo (
				.i_mclk      (i_mclk),
				.i_reset     (i_reset),
				.i_in_valid  (wr_chan && i_addr == duhp_pkg::REG_DATA),
				.i_in_data   (i_data),
				.o_in_ready  (tx_in_ready),
				.o_out_valid (tx_valid),
				.o_out_data  (tx_byte),
				.i_out_ready (tx_pop),
				.o_level     (tx_level)
			);

			assign cts_ok = !efr_ff[duhp_pkg::EFR_CTS_BIT] || !i_clear_send_n[ch];
			assign tx_pop = (tx_state_ff == TX_IDLE) && cts_ok;

			// transmitter: start, eight data, stop; writes to a full fifo are dropped
			always_ff @(posedge i_mclk)
			begin
				if (i_reset)
				begin
					tx_state_ff <= TX_IDLE;
					bit_ff      <= 4'h0;
					tick_ff     <= 5'h00;
					shift_ff    <= 10'h3ff;
				end
				else
				begin
					case (tx_state_ff)
						TX_IDLE:
						begin
							if (tx_valid && cts_ok)
							begin
								shift_ff    <= {1'b1, tx_byte, 1'b0};
								bit_ff      <= 4'h0;
								tick_ff     <= 5'h00;
								tx_state_ff <= TX_SHIFT;
							end
						end
						default:
						begin
							if (tick_ff == 5'(duhp_pkg::BIT_CYCLES - 1))
							begin
								tick_ff  <= 5'h00;
								shift_ff <= {1'b1, shift_ff[9:1]};
								bit_ff   <= bit_ff + 4'h1;
								if (bit_ff == 4'h9)
									tx_state_ff <= TX_IDLE;
							end
							else
								tick_ff <= tick_ff + 5'h01;
						end
					endcase
				end
			end

			// idle line is high in standard mode, low in infrared mode
			always_ff @(posedge i_mclk)
			begin
				if (i_reset)
					line_ff <= 1'b1;
				else if (mcr_ff[duhp_pkg::MCR_IR_BIT])
					line_ff <= (tx_state_ff == TX_SHIFT) && !shift_ff[0]
						&& (tick_ff < 5'(duhp_pkg::IR_PULSE_CYC));
				else
					line_ff <= (tx_state_ff == TX_SHIFT) ? shift_ff[0] : 1'b1;
			end
			assign o_serial_out[ch] = line_ff;

			// infrared receive pulses may arrive inverted
			assign rx_bit = i_serial_in[ch] ^ (mcr_ff[duhp_pkg::MCR_IR_BIT]
				&& feature_control_reg_ff[duhp_pkg::FEATURE_CONTROL_REG_IRINV_BIT]);

			// RS485 mode drives the line turnaround from the transmitter
			assign o_request_send_n[ch] = (feature_control_reg_ff[duhp_pkg::FEATURE_CONTROL_REG_485_BIT])
				? !((tx_state_ff == TX_SHIFT) ^ enhanced_mode_select_reg_ff[duhp_pkg::ENHANCED_MODE_SELECT_REG_485_BIT])
				: !mcr_ff[duhp_pkg::MCR_RTS_BIT];
			assign o_terminal_ready_n[ch] = !mcr_ff[duhp_pkg::MCR_DTR_BIT];

			assign tx_rdy[ch] = {4'h0, tx_level} <= thr_ff;
			assign rx_rdy[ch] = !rx_bit;
			assign irq_oe[ch] = mcr_ff[duhp_pkg::MCR_OUT2_BIT];

			// readback; set-ready, carrier and ring inputs are status only
			always_comb
			begin
				if (i_addr == duhp_pkg::REG_MODEM_CTL)
					rd_data[ch] = mcr_ff;
				else if (i_addr == duhp_pkg::REG_FEATURE)
					rd_data[ch] = feature_control_reg_ff;
				else if (i_addr == duhp_pkg::REG_ENH_FEAT)
					rd_data[ch] = efr_ff;
				else if (i_addr == duhp_pkg::REG_ENH_MODE)
					rd_data[ch] = enhanced_mode_select_reg_ff;
				else if (i_addr == duhp_pkg::REG_LINE_STAT)
					rd_data[ch] = {3'h0, tx_in_ready, tx_level};
				else if (i_addr == duhp_pkg::REG_MODEM_STAT)
					rd_data[ch] = {~i_carrier_n[ch], ~i_ring_n[ch], ~i_set_ready_n[ch],
						~i_clear_send_n[ch], 3'h0, rx_bit};
				else if (i_addr == duhp_pkg::REG_READY_THR)
					rd_data[ch] = thr_ff;
				else
					rd_data[ch] = 8'h00;
			end
		end
	endgenerate

	// strobe style: per-channel irq enabled by out2 bit; R/W style: channel a irq is open drain for both channels, channel b unchanged
	always_comb
	begin
		if (style_ff)
		begin
			o_chan_a_irq    = i_irq_pending[0];
			o_chan_a_irq_oe = irq_oe[0];
		end
		else
		begin
			o_chan_a_irq    = 1'b0;
			o_chan_a_irq_oe = |i_irq_pending;
		end
	end
	assign o_chan_b_irq        = i_irq_pending[1];
	assign o_chan_b_irq_oe     = irq_oe[1];
	assign o_chan_a_gp_out2_n  = !irq_oe[0];
	assign o_chan_b_gp_out2_n  = !irq_oe[1];
	assign o_chan_a_tx_ready_n = !tx_rdy[0];
	assign o_chan_b_tx_ready_n = !tx_rdy[1];
	assign o_chan_a_rx_ready_n = !rx_rdy[0];
	assign o_chan_b_rx_ready_n = !rx_rdy[1];

	property p_out2_tracks_irq_enable;
		@(posedge i_mclk) disable iff (i_reset) o_chan_b_irq_oe |-> !o_chan_b_gp_out2_n;
	endproperty
	a_out2_tracks_irq_enable: assert property (p_out2_tracks_irq_enable) else $error("out2 wrong");
	property p_read_drives_bus;
		@(posedge i_mclk) disable iff (i_reset) (style_ff && rd_act && sel != 2'b00) |=> o_data_oe;
	endproperty
	a_read_drives_bus: assert property (p_read_drives_bus) else $error("bus not driven");
	sequence s_read_start;
		style_ff && rd_start && sel == 2'b01 && i_addr == duhp_pkg::REG_MODEM_CTL;
	endsequence
	property p_read_returns_reg;
		@(posedge i_mclk) disable iff (i_reset) s_read_start |=> o_data == $past(g_chan[0].mcr_ff);
	endproperty
	a_read_returns_reg: assert property (p_read_returns_reg) else $error("read byte wrong");
	property p_write_lands;
		@(posedge i_mclk) disable iff (i_reset)
		(g_chan[0].wr_chan && i_addr == duhp_pkg::REG_MODEM_CTL) |=> g_chan[0].mcr_ff == $past(i_data);
	endproperty
	a_write_lands: assert property (p_write_lands) else $error("write not stored");
	property p_reset_quiet;
		@(posedge i_mclk) i_reset |=> o_chan_a_gp_out2_n && o_chan_b_gp_out2_n && !o_chan_b_irq_oe;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("irq or out2 active after reset");
	property p_idle_high;
		@(posedge i_mclk) i_reset |=> o_serial_out == 2'b11;
	endproperty
	a_idle_high: assert property (p_idle_high) else $error("serial out not high in reset");
endmodule // duhp_host_port

// File: rtl/duhp_pkg.sv
/*
 * duhp_pkg: shared constants for the dual-channel host port block.
 * Assumes a single 20 MHz clock; the verification bench also depends on this package.
 */
package duhp_pkg;
	localparam int unsigned REG_ADDR_W    = 3;
	localparam int unsigned DATA_W        = 8;
	localparam int unsigned NUM_CHAN      = 2;
	localparam int unsigned FIFO_DEPTH    = 8;
	// register indices inside one channel (chosen offsets)
	localparam logic [2:0]  REG_DATA      = 3'h0;
	localparam logic [2:0]  REG_MODEM_CTL = 3'h4;
	localparam logic [2:0]  REG_FEATURE   = 3'h1;
	localparam logic [2:0]  REG_ENH_FEAT  = 3'h2;
	localparam logic [2:0]  REG_ENH_MODE  = 3'h3;
	localparam logic [2:0]  REG_LINE_STAT = 3'h5;
	localparam logic [2:0]  REG_MODEM_STAT = 3'h6;
	localparam logic [2:0]  REG_READY_THR = 3'h7;
	// field positions
	localparam int unsigned MCR_DTR_BIT   = 0;
	localparam int unsigned MCR_RTS_BIT   = 1;
	localparam int unsigned MCR_OUT2_BIT  = 3;
	localparam int unsigned MCR_IR_BIT    = 6;
	localparam int unsigned FEATURE_CONTROL_REG_IRINV_BIT = 2;
	localparam int unsigned FEATURE_CONTROL_REG_485_BIT  = 3;
	localparam int unsigned ENHANCED_MODE_SELECT_REG_485_BIT  = 3;
	localparam int unsigned EFR_CTS_BIT   = 7;
	localparam int unsigned EFR_RTS_BIT   = 6;
	// reset values
	localparam logic [7:0]  MCR_RESET     = 8'h00;
	localparam logic [7:0]  CFG_RESET     = 8'h00;
	localparam logic [7:0]  THR_RESET     = 8'h04;
	// serial timing: a simple fixed bit time
	localparam int unsigned BIT_CYCLES    = 16;
	localparam int unsigned IR_PULSE_CYC  = 3;
endpackage : duhp_pkg

// File: rtl/duhp_fifo.sv
/*
 * duhp_fifo: small synchronous FIFO with valid/ready on both sides.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
module duhp_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 8
) (
	// clock and reset
	input  wire logic             i_mclk,
	input  wire logic             i_reset,
	// fill side
	input  wire logic             i_in_valid,
	input  wire logic [WIDTH-1:0] i_in_data,
	output logic                  o_in_ready,
	// drain side
	output logic                  o_out_valid,
	output logic      [WIDTH-1:0] o_out_data,
	input  wire logic             i_out_ready,
	// fill level
	output logic [$clog2(DEPTH):0] o_level
);
	localparam int unsigned AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0]    wr_ptr_ff;
	logic [AW-1:0]    rd_ptr_ff;
	logic [AW:0]      count_ff;
	logic             push;
	logic             pop;

	assign o_in_ready  = (count_ff != DEPTH[AW:0]);
	assign o_out_valid = (count_ff != '0);
	assign o_out_data  = mem_ff[rd_ptr_ff];
	assign o_level     = count_ff;
	assign push        = i_in_valid && o_in_ready;
	assign pop         = o_out_valid && i_out_ready;

	always_ff @(posedge i_mclk)
	begin
		if (push)
			mem_ff[wr_ptr_ff] <= i_in_data;
	end

	always_ff @(posedge i_mclk)
	begin
		if (i_reset)
		begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff  <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_ff <= wr_ptr_ff + 1'b1;
			if (pop)
				rd_ptr_ff <= rd_ptr_ff + 1'b1;
			if (push && !pop)
				count_ff <= count_ff + 1'b1;
			else if (pop && !push)
				count_ff <= count_ff - 1'b1;
		end
	end
endmodule // duhp_fifo

// File: verif/duhp_host_model.sv
/*
 * duhp_host_model: host processor on the 8-bit parallel bus of duhp_host_port.
 * Assumes the bench calls its tasks from one process and drives the strap.
 */
`timescale 1ns/1ps
module duhp_host_model (
	input  wire logic       i_mclk,
	input  wire logic       i_bus_style,
	input  wire logic [7:0] i_rd_data,
	input  wire logic       i_rd_oe,
	output logic      [2:0] o_addr,
	output logic      [7:0] o_bus,
	output logic            o_rd_n,
	output logic            o_wr_n,
	output logic            o_cs_a_n,
	output logic            o_cs_b_n
);
	logic [7:0] drv = 8'h5a;
	logic       rd_idle = 1'b1;
	// no pull-ups here: a released bus shows the inverse of the last written byte
	assign o_bus = i_rd_oe ? i_rd_data : drv;
	initial
	begin
		o_addr = 3'h0;
		idle();
	end
	task automatic idle();
		o_cs_a_n = 1'b1;
		o_cs_b_n = 1'b1;
		o_wr_n   = 1'b1;
		o_rd_n   = i_bus_style | rd_idle;
	endtask
	task automatic sel(input logic ch);
		o_cs_a_n = i_bus_style ? ch : 1'b0;
		o_cs_b_n = i_bus_style ? !ch : ch;
	endtask
	task automatic wr(input logic ch, input logic [2:0] a, input logic [7:0] d);
		@(posedge i_mclk);
		#1;
		o_addr = a;
		drv    = d;
		o_rd_n = i_bus_style | rd_idle;
		sel(ch);
		o_wr_n = 1'b0;
		@(posedge i_mclk);
		#1;
		if (i_bus_style)
		begin
			// byte is taken at the edge that sees the strobe back high
			o_wr_n = 1'b1;
			@(posedge i_mclk);
			#1;
		end
		idle();
		drv = ~d;
	endtask
	task automatic rd(input logic ch, input logic [2:0] a,
		output logic [7:0] d, output logic ok);
		int n;
		@(posedge i_mclk);
		#1;
		ok     = 1'b0;
		d      = 8'h00;
		o_addr = a;
		sel(ch);
		o_rd_n = !i_bus_style;
		for (n = 0; n < 8 && !ok; n++)
		begin
			@(posedge i_mclk);
			if (i_rd_oe === 1'b1)
			begin
				ok = 1'b1;
				d  = i_rd_data;
			end
		end
		#1;
		idle();
	endtask
endmodule // duhp_host_model

// File: verif/tb.sv
/*
 * tb: self-checking bench for duhp_host_port, bus traffic through duhp_host_model.
 * Assumes the offsets and bit positions of duhp_pkg and a 20 MHz clock.
 */
`timescale 1ns/1ps
module tb;
	logic             i_mclk = 1'b0;
	logic             i_reset;
	logic             i_bus_style = 1'b1;
	logic       [1:0] i_irq_pending = 2'h0;
	logic       [1:0] i_serial_in = 2'h3;
	logic       [1:0] i_clear_send_n = 2'h0;
	logic       [1:0] i_modem_in_n = 2'h3;
	wire  logic [2:0] addr;
	wire  logic [7:0] bus, rdata;
	wire  logic       oe, rd_n, wr_n, cs_a_n, cs_b_n;
	wire  logic       irq_a, irq_a_oe, irq_b, irq_b_oe, out2_a_n, out2_b_n;
	wire  logic       txr_a_n, rxr_a_n, txr_b_n, rxr_b_n;
	wire  logic [1:0] ser, rts_n, dtr_n;
	wire  logic [15:0] pins = {3'h0, oe, irq_a_oe, irq_b_oe, out2_a_n, out2_b_n,
		ser, rts_n, dtr_n, txr_a_n, txr_b_n};
	int               miscompares = 0;
	int               compares = 0;
	int               falls = 0;
	logic       [7:0] rv;
	logic             ok;
	logic       [2:0] regs [4] = '{duhp_pkg::REG_FEATURE, duhp_pkg::REG_ENH_FEAT,
		duhp_pkg::REG_ENH_MODE, duhp_pkg::REG_READY_THR};
	initial
	begin
		forever #25 i_mclk = ~i_mclk;
	end
	always @(negedge ser[0]) falls++;
	duhp_host_port DUT (
		.i_mclk(i_mclk), .i_reset(i_reset), .i_bus_style(i_bus_style),
		.i_addr(addr), .i_data(bus), .o_data(rdata), .o_data_oe(oe),
		.i_read_strobe_n(rd_n), .i_write_strobe_n(wr_n),
		.i_chan_a_select_n(cs_a_n), .i_chan_b_select_n(cs_b_n),
		.i_irq_pending(i_irq_pending), .o_chan_a_irq(irq_a), .o_chan_a_irq_oe(irq_a_oe),
		.o_chan_b_irq(irq_b), .o_chan_b_irq_oe(irq_b_oe),
		.o_chan_a_gp_out2_n(out2_a_n), .o_chan_b_gp_out2_n(out2_b_n),
		.o_chan_a_tx_ready_n(txr_a_n), .o_chan_a_rx_ready_n(rxr_a_n),
		.o_chan_b_tx_ready_n(txr_b_n), .o_chan_b_rx_ready_n(rxr_b_n),
		.o_serial_out(ser), .i_serial_in(i_serial_in), .o_request_send_n(rts_n),
		.i_clear_send_n(i_clear_send_n), .o_terminal_ready_n(dtr_n),
		.i_set_ready_n(i_modem_in_n), .i_carrier_n(i_modem_in_n), .i_ring_n(i_modem_in_n)
	);
	duhp_host_model host (
		.i_mclk(i_mclk), .i_bus_style(i_bus_style), .i_rd_data(rdata), .i_rd_oe(oe),
		.o_addr(addr), .o_bus(bus), .o_rd_n(rd_n), .o_wr_n(wr_n),
		.o_cs_a_n(cs_a_n), .o_cs_b_n(cs_b_n)
	);
	task automatic end_sim();
		$display("compares=%0d miscompares=%0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp)
		begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_end(input logic [15:0] got, input logic [15:0] exp);
		chk(got, exp);
		end_sim();
	endtask
	task automatic rdc(input logic ch, input logic [2:0] a, input logic [7:0] exp);
		host.rd(ch, a, rv, ok);
		if (ok !== 1'b1)
			chk_end({15'h0, ok}, 16'h0001);
		chk({8'h00, rv}, {8'h00, exp});
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge i_mclk);
		#1;
	endtask
	task automatic do_reset(input logic style);
		i_reset     = 1'b1;
		i_bus_style = style;
		tick(12);
		i_reset = 1'b0;
		tick(1);
	endtask
	initial
	begin
		do_reset(1'b1);
		chk(pins, 16'h03fc);
		$display("reset test done");
		for (int c = 0; c < 2; c++)
			for (int i = 0; i < 4; i++)
				host.wr(c[0], regs[i], {1'b0, c[0], 3'h0, regs[i]});
		for (int c = 0; c < 2; c++)
			for (int i = 0; i < 4; i++)
				rdc(c[0], regs[i], {1'b0, c[0], 3'h0, regs[i]});
		// threshold of channel a stays at 7 for the fill test
		for (int c = 0; c < 2; c++)
			for (int i = 0; i < 3; i++)
				host.wr(c[0], regs[i], 8'h00);
		$display("register test done");
		host.wr(1'b0, duhp_pkg::REG_MODEM_CTL, 8'h0b);
		host.wr(1'b1, duhp_pkg::REG_MODEM_CTL, 8'h08);
		tick(2);
		chk(pins, 16'h0ce8);
		i_irq_pending = 2'h3;
		tick(1);
		chk({14'h0, irq_a, irq_b}, 16'h0003);
		i_irq_pending = 2'h0;
		rdc(1'b0, duhp_pkg::REG_MODEM_CTL, 8'h0b);
		host.wr(1'b0, duhp_pkg::REG_MODEM_CTL, 8'h00);
		host.wr(1'b1, duhp_pkg::REG_MODEM_CTL, 8'h00);
		tick(2);
		chk(pins, 16'h03fc);
		$display("modem control test done");
		i_serial_in = 2'h2;
		tick(3);
		chk({14'h0, rxr_a_n, rxr_b_n}, 16'h0001);
		host.wr(1'b0, duhp_pkg::REG_MODEM_CTL, 8'h40);
		host.wr(1'b0, duhp_pkg::REG_FEATURE, 8'h04);
		i_serial_in = 2'h3;
		tick(3);
		chk({14'h0, ser[0], rxr_a_n}, 16'h0000);
		i_serial_in = 2'h2;
		tick(3);
		chk({14'h0, ser[0], rxr_a_n}, 16'h0001);
		host.wr(1'b0, duhp_pkg::REG_MODEM_CTL, 8'h00);
		host.wr(1'b0, duhp_pkg::REG_FEATURE, 8'h00);
		i_serial_in = 2'h3;
		tick(3);
		chk({14'h0, ser[0], rxr_a_n}, 16'h0003);
		$display("receive and infrared test done");
		i_clear_send_n = 2'h1;
		host.wr(1'b0, duhp_pkg::REG_ENH_FEAT, 8'h80);
		falls = 0;
		// all-ones bytes: exactly one falling edge per frame
		for (int i = 0; i < 7; i++)
			host.wr(1'b0, duhp_pkg::REG_DATA, 8'hff);
		tick(2);
		chk({15'h0, txr_a_n}, 16'h0000);
		host.wr(1'b0, duhp_pkg::REG_DATA, 8'hff);
		host.wr(1'b0, duhp_pkg::REG_DATA, 8'hff);
		tick(2);
		chk({15'h0, txr_a_n}, 16'h0001);
		tick(64);
		chk(falls[15:0], 16'h0000);
		i_clear_send_n = 2'h0;
		i_modem_in_n   = 2'h0;
		for (int n = 0; n < 3000 && falls < 8; n++)
			tick(1);
		if (falls < 8)
			chk_end(falls[15:0], 16'h0008);
		tick(200);
		chk(falls[15:0], 16'h0008);
		chk({14'h0, ser[0], txr_a_n}, 16'h0002);
		$display("transmit fifo test done");
		do_reset(1'b0);
		host.wr(1'b1, duhp_pkg::REG_MODEM_CTL, 8'h02);
		host.wr(1'b0, duhp_pkg::REG_MODEM_CTL, 8'h01);
		tick(2);
		chk({12'h0, rts_n, dtr_n}, 16'h0006);
		rdc(1'b1, duhp_pkg::REG_MODEM_CTL, 8'h02);
		rdc(1'b0, duhp_pkg::REG_MODEM_CTL, 8'h01);
		host.rd_idle = 1'b0;
		host.wr(1'b0, duhp_pkg::REG_FEATURE, 8'h01);
		chk({15'h0, oe}, 16'h0000);
		host.rd_idle = 1'b1;
		rdc(1'b0, duhp_pkg::REG_FEATURE, 8'h01);
		i_irq_pending = 2'h2;
		tick(3);
		chk({14'h0, irq_a_oe, irq_a}, 16'h0002);
		i_irq_pending = 2'h0;
		tick(3);
		chk({15'h0, irq_a_oe}, 16'h0000);
		$display("read/write style test done");
		end_sim();
	end
endmodule // tb
